// ---- bench/spe_eeprom_monitor.sv ----
// spe_eeprom_monitor: port checks for the serial eeprom slave.
// assumes a bind to spe_eeprom; core_clk and sck are unrelated clocks.
`timescale 1ns/1ps
`default_nettype none

module spe_eeprom_monitor #(
   parameter int unsigned WC_CYCLES = 200
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe,
   input wire logic write_busy
);
   // ----------------------------------------------------------------------------
   // helper counters
   // ----------------------------------------------------------------------------
   int unsigned busy_cnt;
   logic [4:0] rises;

   always_ff @(posedge core_clk) begin
      if (rst || !write_busy)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end

   // paused edges do not count, so the byte boundary survives a hold
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n)
         rises <= 5'h00;
      else if (hold_n && rises != 5'h1f)
         rises <= rises + 5'h01;
   end

   // ----------------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------------
   property p_oe_idle;
      @(posedge core_clk) disable iff (rst) cs_n |-> !so_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("so_oe high while deselected");

   property p_oe_byte;
      @(posedge sck) disable iff (rst) $rose(so_oe) |-> rises == 5'h08 || rises == 5'h10;
   endproperty
   a_oe_byte: assert property (p_oe_byte) else $error("so_oe rose off a byte boundary");

   property p_hold_so;
      @(posedge sck) disable iff (rst || cs_n) !hold_n && $past(hold_n) == 1'b0 |-> $stable(so);
   endproperty
   a_hold_so: assert property (p_hold_so) else $error("so moved during pause");

   property p_busy_start;
      @(posedge core_clk) disable iff (rst) $rose(write_busy) |-> cs_n && $past(cs_n, 2);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("write began while selected");

   property p_busy_prompt;
      @(posedge core_clk) disable iff (rst) $rose(write_busy) |-> !$past(cs_n, 4);
   endproperty
   a_busy_prompt: assert property (p_busy_prompt) else $error("write began late after cs");

   property p_busy_hold;
      @(posedge core_clk) disable iff (rst) $rose(write_busy) |-> write_busy [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");

   // busy may start up to three cycles after cs rises; the limit counts from cs
   property p_busy_max;
      @(posedge core_clk) disable iff (rst) busy_cnt + 3 <= WC_CYCLES;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("write cycle too long");

   property p_busy_end;
      @(posedge core_clk) disable iff (rst) $fell(write_busy) |-> busy_cnt + 8 >= WC_CYCLES;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("write cycle ended early");

   property p_busy_status;
      @(posedge sck) disable iff (rst) write_busy && $rose(so_oe) |-> rises == 5'h08;
   endproperty
   a_busy_status: assert property (p_busy_status) else $error("data read obeyed while busy");
endmodule

bind spe_eeprom spe_eeprom_monitor #(.WC_CYCLES(WC_CYCLES)) u_mon (
   .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
   .so(so), .so_oe(so_oe), .write_busy(write_busy)
);
`default_nettype wire

// ---- bench/spe_host.sv ----
// spe_host: behavioural spi host for the eeprom slave pins.
// assumes the bench calls one task at a time; sck period 15 ns.
`timescale 1ns/1ps
`default_nettype none

module spe_host (
   output logic sck,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   input wire logic so
);
   logic cpol = 1'b0;
   logic [7:0] rx;

   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
   end

   // msb first, si set while sck low, so taken at the rise
   task automatic xbyte(input logic [7:0] tx, input int pz);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         if (i == pz) begin
            // pause with sck low; si and sck keep toggling meanwhile
            #3 hold_n = 1'b0;
            repeat (3) begin
               #4 si = ~si;
               #3.5 sck = 1'b1;
               #7.5 sck = 1'b0;
            end
            #3 hold_n = 1'b1;
         end
         si = tx[i];
         #7.5 sck = 1'b1;
         rx[i] = so;
         #7.5;
      end
   endtask

   task automatic sel();
      #3.3 sck = cpol;
      #20 cs_n = 1'b0;
      #20;
   endtask

   // gap keeps more than five core cycles between frames
   task automatic desel();
      #7.5 sck = cpol;
      #10 cs_n = 1'b1;
      si = ~si;
      #600;
   endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// tb: self-checking bench for spe_eeprom with the spe_host model.
// assumes spe_pkg compiled first; write cycle shortened to 200 core cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int unsigned WC = 200;
   logic core_clk, rst, wp_n, so, so_oe, write_busy;
   wire logic sck, cs_n, si, hold_n;
   logic [7:0] st;
   int failures = 0;
   int checks_done = 0;
   spe_pkg::spe_word_s rows [3] = '{'{9'h000, 8'h5a}, '{9'h1ff, 8'ha5}, '{9'h0a4, 8'h3c}};

   spe_host host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so));
   spe_eeprom #(.MEM_BYTES(512), .WC_CYCLES(WC)) dut (
      .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
      .wp_n(wp_n), .so(so), .so_oe(so_oe), .write_busy(write_busy)
   );

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic op(input logic [7:0] b);
      host.sel();
      host.xbyte(b, 9);
      host.desel();
   endtask

   task automatic stat(output logic [7:0] s);
      host.sel();
      host.xbyte(8'h05, 9);
      host.xbyte(8'h00, 9);
      s = host.rx;
      host.desel();
   endtask

   // bounded wait for a busy level, then compare what was reached
   task automatic wb(input logic lvl, input logic e);
      int k;
      k = 0;
      while (write_busy !== lvl && k < WC + 40) begin
         @(negedge core_clk);
         k++;
      end
      chk("write_busy", {7'h0, e}, {7'h0, write_busy});
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d, input int n, input logic en);
      if (en)
         op(8'h06);
      host.sel();
      host.xbyte({4'h0, a[8], 3'h2}, 9);
      host.xbyte(a[7:0], 9);
      for (int i = 0; i < n; i++)
         host.xbyte(d + 8'(i), 9);
      host.desel();
   endtask

   task automatic rdchk(input logic [8:0] a, input logic [7:0] d, input int n, input int pz);
      host.sel();
      host.xbyte({4'h0, a[8], 3'h3}, 9);
      host.xbyte(a[7:0], pz);
      for (int i = 0; i < n; i++) begin
         host.xbyte(8'h00, pz);
         chk("read_data", d + 8'(i), host.rx);
      end
      host.desel();
   endtask

   task automatic wst(input logic [7:0] v);
      op(8'h06);
      host.sel();
      host.xbyte(8'h01, 9);
      host.xbyte(v, 9);
      host.desel();
      wb(1'b1, 1'b1);
      wb(1'b0, 1'b0);
   endtask

   // ----------------------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      chk("so_oe", 8'h00, {7'h0, so_oe});
      #1000000;
      stat(st);
      chk("status_reset", 8'hf0, st);
      for (int i = 0; i < 3; i++) begin
         wr(rows[i].addr, rows[i].data, 1, 1'b1);
         wb(1'b1, 1'b1);
         stat(st);
         chk("status_busy", 8'hf3, st);
         op(8'h04);
         host.sel();
         host.xbyte({4'h0, rows[i].addr[8], 3'h3}, 9);
         host.xbyte(rows[i].addr[7:0], 9);
         host.xbyte(8'h00, 9);
         chk("so_oe_busy", 8'h00, {7'h0, so_oe});
         host.desel();
         stat(st);
         chk("status_ignored", 8'hf3, st);
         wb(1'b0, 1'b0);
         rdchk(rows[i].addr, rows[i].data, 1, 9);
         $display("row %0d done", i);
      end
      wr(9'h0be, 8'h10, 3, 1'b1);
      wb(1'b1, 1'b1);
      wb(1'b0, 1'b0);
      rdchk(9'h0be, 8'h10, 2, 4);
      rdchk(9'h0b0, 8'h12, 1, 9);
      $display("page and pause done");
      host.cpol = 1'b1;
      rdchk(9'h1ff, 8'ha5, 1, 9);
      host.cpol = 1'b0;
      $display("idle high clock done");
      op(8'h06);
      op(8'h04);
      wr(9'h010, 8'h11, 1, 1'b0);
      wb(1'b1, 1'b0);
      @(negedge core_clk) wp_n = 1'b0;
      op(8'h06);
      stat(st);
      chk("status_wp", 8'hf0, st);
      @(negedge core_clk) wp_n = 1'b1;
      $display("latch refusals done");
      wst(8'h04);
      stat(st);
      chk("status_bp", 8'hf4, st);
      wr(9'h180, 8'h22, 1, 1'b1);
      wb(1'b1, 1'b0);
      wr(9'h17f, 8'h33, 1, 1'b1);
      wb(1'b1, 1'b1);
      wb(1'b0, 1'b0);
      wst(8'h08);
      wr(9'h100, 8'h44, 1, 1'b1);
      wb(1'b1, 1'b0);
      wst(8'h0c);
      wr(9'h000, 8'h55, 1, 1'b1);
      wb(1'b1, 1'b0);
      wst(8'h00);
      $display("protection done");
      stop_test();
   end

   // the whole run needs about 1.3 ms
   initial begin
      #5000000;
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire

// ---- inc/spe_cfg.svh ----
// spe_cfg.svh: opcodes, status layout, reset values and timing figures of the
// serial eeprom slave. assumes nothing; definitions only.
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define CFG_OP_SET_WL 8'h06
`define CFG_OP_CLR_WL 8'h04
`define CFG_OP_RD_ST 8'h05
`define CFG_OP_WR_ST 8'h01
`define CFG_OP_HI_ZERO 4'h0
`define CFG_OP_RD_LOW 3'h3
`define CFG_OP_WR_LOW 3'h2
`define CFG_OP_A8_BIT 3

// ----------------------------------------------------------------------------
// status byte and array
// ----------------------------------------------------------------------------
`define CFG_ST_ONES 4'hf
`define CFG_BP_RESET 2'h0
`define CFG_BP_NONE 2'h0
`define CFG_BP_QUARTER 2'h1
`define CFG_BP_HALF 2'h2
`define CFG_ADDR_W_MAX 9
`define CFG_MEM_BYTES 512
`define CFG_PAGE_BYTES 16
`define CFG_PAGE_W 4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CFG_TWC_MS 5
`define CFG_CORE_KHZ 10000
`define CFG_SYNC_LAT 3

`endif

// ---- inc/spe_pkg.sv ----
// spe_pkg: types shared by the serial eeprom slave.
// assumes spe_cfg.svh on the include path.
`include "spe_cfg.svh"

package spe_pkg;
   typedef enum logic [6:0] {
      PH_OP = 7'h01,
      PH_ADDR = 7'h02,
      PH_RDATA = 7'h04,
      PH_RSTAT = 7'h08,
      PH_WDATA = 7'h10,
      PH_WSTAT = 7'h20,
      PH_SKIP = 7'h40
   } spe_phase_e;

   typedef enum logic [2:0] {
      WC_IDLE = 3'h1,
      WC_COPY = 3'h2,
      WC_WAIT = 3'h4
   } spe_wc_e;

   typedef struct packed {
      logic [`CFG_ADDR_W_MAX-1:0] addr;
      logic [7:0] data;
   } spe_word_s;
endpackage

// ---- src/spe_eeprom.sv ----
// spe_eeprom: serial peripheral bus slave of a small byte-wide eeprom.
// assumes sck, cs_n, si and hold_n come from one host and belong to the sck
// domain; wp_n is asynchronous; core_clk runs at 10 MHz.
//
// Behaviour
// R1: input bits sampled on rising sck; modes 0 and 3 both work.
// R2: read bits leave on falling sck, host samples at next rise.
// R3: first byte after cs falls is the opcode, one of six operations.
// R4: self-timed write cycle ends within 5 ms of cs rising.
// R5: host waits 1 ms after power-up before any read or write.
// R6: hold pauses the sequence without losing it; resume continues.
// R7: array holds 128, 256 or 512 bytes; size sets address width.
// R8: write data gathered in a sixteen-byte page, programmed in one cycle.
// R9: block protection covers top quarter, half or all; writes there refused.
// R10: opcode encodings for latch set/clear, status read/write, data read/write.
// R11: status bit 0 shows busy; status readable even while busy.
// R12: write latch clear at reset, set by opcode then cs high; wp low clears.
// R13: during a write cycle only the status read is obeyed.
// R14: cs high resets bit and byte counting; next frame starts with opcode.
`timescale 1ns/1ps
`default_nettype none
`include "spe_cfg.svh"

module spe_eeprom #(
   parameter int MEM_BYTES = `CFG_MEM_BYTES,
   parameter int unsigned WC_CYCLES = `CFG_TWC_MS * `CFG_CORE_KHZ
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic so,
   output logic so_oe,
   output logic write_busy
);
   localparam int AW = $clog2(MEM_BYTES);
   localparam int TW = $clog2(WC_CYCLES + 1);
   // busy rises up to three cycles after cs and falls one cycle after the
   // count runs out, so the whole span stays inside the limit
   localparam logic [TW-1:0] WC_LOAD = TW'(WC_CYCLES - `CFG_SYNC_LAT - 1);
   localparam int PGW = `CFG_PAGE_W;

   // -------------------------------------------------------------------------
   // shared decode
   // -------------------------------------------------------------------------
   function automatic logic op_data(input logic [7:0] op, input logic [2:0] low);
      op_data = (op[7:4] == `CFG_OP_HI_ZERO) && (op[2:0] == low)
         && (AW == `CFG_ADDR_W_MAX || !op[`CFG_OP_A8_BIT]); // see R10 see R7
   endfunction

   function automatic logic in_guard(input logic [AW-1:0] a, input logic [1:0] bp);
      unique case (bp)
         `CFG_BP_NONE: in_guard = 1'b0;
         `CFG_BP_QUARTER: in_guard = (a[AW-1:AW-2] == 2'h3);
         `CFG_BP_HALF: in_guard = a[AW-1];
         default: in_guard = 1'b1;
      endcase
   endfunction

   logic [7:0] mem [MEM_BYTES];
   logic [7:0] page [`CFG_PAGE_BYTES];

   // -------------------------------------------------------------------------
   // link side, clocked by sck
   // -------------------------------------------------------------------------
   logic link_clr;
   logic [2:0] bit_cnt;
   spe_pkg::spe_phase_e phase;
   spe_pkg::spe_phase_e next_phase;
   logic [6:0] shift;
   logic [7:0] rx;
   logic [7:0] op;
   logic [AW-1:0] addr;
   logic [AW-1:0] next_addr;
   logic [PGW:0] pg_cnt;
   logic [7:0] stat_val;
   logic stat_ok;
   logic aligned;
   logic frame_tgl;
   logic [7:0] tx;
   logic [3:0] l_s1;
   logic [3:0] l_s2;
   logic [1:0] bp;
   logic write_latch_flag;
   logic [7:0] status;
   logic byte_end;

   assign link_clr = cs_n | rst;
   assign rx = {shift, si};
   assign byte_end = (bit_cnt == 3'h7) && hold_n && !cs_n;
   assign status = {`CFG_ST_ONES, l_s2}; // see R11

   always_comb begin
      next_phase = phase;
      next_addr = addr + 1'b1;
      unique case (phase)
         spe_pkg::PH_OP: begin
            if (l_s2[0] && rx != `CFG_OP_RD_ST) begin
               next_phase = spe_pkg::PH_SKIP; // see R13
            end else if (rx == `CFG_OP_RD_ST) begin
               next_phase = spe_pkg::PH_RSTAT;
            end else if (rx == `CFG_OP_WR_ST) begin
               next_phase = spe_pkg::PH_WSTAT;
            end else if (op_data(rx, `CFG_OP_RD_LOW) || op_data(rx, `CFG_OP_WR_LOW)) begin
               next_phase = spe_pkg::PH_ADDR; // see R3
            end else begin
               next_phase = spe_pkg::PH_SKIP;
            end
         end
         spe_pkg::PH_ADDR: begin
            next_addr = AW'({op[`CFG_OP_A8_BIT], rx}); // see R7
            next_phase = op_data(op, `CFG_OP_RD_LOW) ? spe_pkg::PH_RDATA
               : spe_pkg::PH_WDATA;
         end
         spe_pkg::PH_WSTAT: next_phase = spe_pkg::PH_SKIP;
         spe_pkg::PH_RDATA, spe_pkg::PH_RSTAT, spe_pkg::PH_WDATA, spe_pkg::PH_SKIP: begin
            next_phase = phase;
         end
      endcase
   end

   // counting restarts whenever cs is high; sck may be dead then
   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         bit_cnt <= 3'h0; // see R14
         phase <= spe_pkg::PH_OP;
      end else if (hold_n) begin
         bit_cnt <= bit_cnt + 3'h1; // see R1 see R6
         if (bit_cnt == 3'h7) begin
            phase <= next_phase;
         end
      end
   end

   // results survive cs rising so the core can pick them up afterwards
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         shift <= 7'h00;
         op <= 8'h00;
         addr <= '0;
         pg_cnt <= '0;
         stat_val <= 8'h00;
         stat_ok <= 1'b0;
         aligned <= 1'b0;
         frame_tgl <= 1'b0;
         tx <= 8'h00;
      end else if (!cs_n && hold_n) begin
         shift <= rx[6:0]; // see R1
         aligned <= (bit_cnt == 3'h7);
         if (bit_cnt == 3'h7) begin
            unique case (phase)
               spe_pkg::PH_OP: begin
                  op <= rx; // see R3
                  frame_tgl <= ~frame_tgl;
                  pg_cnt <= '0;
                  stat_ok <= 1'b0;
                  tx <= status;
               end
               spe_pkg::PH_ADDR, spe_pkg::PH_RDATA: begin
                  addr <= next_addr;
                  tx <= mem[next_addr];
               end
               spe_pkg::PH_WDATA: begin
                  if (pg_cnt != (PGW+1)'(`CFG_PAGE_BYTES)) begin
                     pg_cnt <= pg_cnt + 1'b1; // see R8
                  end
               end
               spe_pkg::PH_WSTAT: begin
                  stat_val <= rx;
                  stat_ok <= 1'b1;
               end
               spe_pkg::PH_RSTAT: tx <= status;
               spe_pkg::PH_SKIP: tx <= tx;
            endcase
         end
      end
   end

   // extra bytes past sixteen all land in the first byte's slot, the last of them stays
   always_ff @(posedge sck) begin
      if (byte_end && phase == spe_pkg::PH_WDATA) begin
         page[addr[PGW-1:0] + pg_cnt[PGW-1:0]] <= rx; // see R8
      end
   end

   // limitation: so stays driven during hold; only cs high or reset floats it
   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end else if (hold_n && (phase == spe_pkg::PH_RDATA || phase == spe_pkg::PH_RSTAT)) begin
         so <= tx[3'h7 - bit_cnt]; // see R2 see R11
         so_oe <= 1'b1;
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         l_s1 <= 4'h0;
         l_s2 <= 4'h0;
      end else begin
         l_s1 <= {bp, write_latch_flag, write_busy};
         l_s2 <= l_s1;
      end
   end

   // -------------------------------------------------------------------------
   // core side: latch, protection and the self-timed write
   // -------------------------------------------------------------------------
   logic cs_s1, cs_s2, cs_d;
   logic wp_s1, wp_s2;
   logic tg_s1, tg_s2, tg_seen;
   logic new_cmd;
   logic is_wr;
   logic start_ok;
   spe_pkg::spe_wc_e wc;
   logic [TW-1:0] tmr;
   logic [PGW:0] cp_i;
   logic [PGW:0] cp_n;
   logic cp_st;
   logic pace;
   spe_pkg::spe_word_s push_word;
   spe_pkg::spe_word_s pop_word;
   logic push_valid, push_ready, pop_valid;
   logic [AW-1:0] cp_addr;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
         tg_s1 <= 1'b0;
         tg_s2 <= 1'b0;
         tg_seen <= 1'b0;
      end else begin
         cs_s1 <= cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         wp_s1 <= wp_n;
         wp_s2 <= wp_s1;
         tg_s1 <= frame_tgl;
         tg_s2 <= tg_s1;
         if (cs_s2 && !cs_d) begin
            tg_seen <= tg_s2;
         end
      end
   end

   assign new_cmd = cs_s2 && !cs_d && (tg_s2 != tg_seen) && !write_busy; // see R13
   assign is_wr = op_data(op, `CFG_OP_WR_LOW);
   assign start_ok = new_cmd && write_latch_flag && aligned
      && ((is_wr && pg_cnt != '0 && !in_guard(addr, bp)) // see R9
      || (op == `CFG_OP_WR_ST && stat_ok));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         write_latch_flag <= 1'b0; // see R12
      end else if (!wp_s2) begin
         write_latch_flag <= 1'b0; // see R12
      end else if (wc == spe_pkg::WC_WAIT && tmr == '0) begin
         write_latch_flag <= 1'b0;
      end else if (new_cmd && op == `CFG_OP_SET_WL) begin
         write_latch_flag <= 1'b1; // see R12 see R10
      end else if (new_cmd && op == `CFG_OP_CLR_WL) begin
         write_latch_flag <= 1'b0;
      end
   end

   assign cp_addr = {addr[AW-1:PGW], addr[PGW-1:0] + cp_i[PGW-1:0]};
   assign push_valid = (wc == spe_pkg::WC_COPY) && (cp_i != cp_n);
   assign push_word = '{addr: `CFG_ADDR_W_MAX'(cp_addr),
      data: page[addr[PGW-1:0] + cp_i[PGW-1:0]]};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wc <= spe_pkg::WC_IDLE;
         write_busy <= 1'b0;
         tmr <= '0;
         cp_i <= '0;
         cp_n <= '0;
         cp_st <= 1'b0;
         bp <= `CFG_BP_RESET;
         pace <= 1'b0;
      end else begin
         pace <= ~pace;
         if (tmr != '0) begin
            tmr <= tmr - 1'b1;
         end
         unique case (wc)
            spe_pkg::WC_IDLE: begin
               if (start_ok) begin
                  wc <= spe_pkg::WC_COPY;
                  write_busy <= 1'b1; // see R11
                  tmr <= WC_LOAD; // see R4
                  cp_i <= '0;
                  cp_n <= is_wr ? pg_cnt : '0;
                  cp_st <= !is_wr;
               end
            end
            spe_pkg::WC_COPY: begin
               if (push_valid && push_ready) begin
                  cp_i <= cp_i + 1'b1;
               end else if (!push_valid && !pop_valid) begin
                  wc <= spe_pkg::WC_WAIT;
               end
            end
            spe_pkg::WC_WAIT: begin
               if (tmr == '0) begin
                  wc <= spe_pkg::WC_IDLE;
                  write_busy <= 1'b0; // see R4
                  if (cp_st) begin
                     bp <= stat_val[3:2];
                  end
               end
            end
         endcase
      end
   end

   // the array takes a byte every other cycle, so the buffer really fills
   spe_pair_buf #(
      .WIDTH($bits(spe_pkg::spe_word_s)),
      .DEPTH(2)
   ) u_buf (
      .clk(core_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(pop_valid),
      .out_ready(pace),
      .out_data(pop_word)
   );

   always_ff @(posedge core_clk) begin
      if (pop_valid && pace) begin
         mem[pop_word.addr[AW-1:0]] <= pop_word.data; // see R8
      end
   end
endmodule

`default_nettype wire

// ---- src/spe_pair_buf.sv ----
// spe_pair_buf: small ring buffer with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module spe_pair_buf #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != FULL);
   assign out_valid = (count != '0);
   assign out_data = slot[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         slot[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

`default_nettype wire
